// ==== hdl/lgt_pkg.sv ====
// Constants shared by the logic tile: register map, field positions, resets.
// Assumes a 32-bit plain register port with byte addresses on 8 bits.
package lgt_pkg;
	localparam int LGT_NLUT = 8;
	localparam int LGT_NFF = 9;
	localparam int LGT_FB_W = 8;

	localparam logic [7:0] LGT_OFS_LUT0 = 8'h00;
	localparam logic [7:0] LGT_OFS_CTRL = 8'h20;
	localparam logic [7:0] LGT_OFS_GROUP = 8'h24;
	localparam logic [7:0] LGT_OFS_MODE = 8'h28;
	localparam logic [7:0] LGT_OFS_SRVAL = 8'h2C;
	localparam logic [7:0] LGT_OFS_F5EN = 8'h30;
	localparam logic [7:0] LGT_OFS_FB = 8'h34;
	localparam logic [7:0] LGT_OFS_STATUS = 8'h38;

	// Control input order inside the disable and invert fields
	localparam int LGT_IN_CLK = 0;
	localparam int LGT_IN_LSR = 1;
	localparam int LGT_IN_CE = 2;
	localparam int LGT_IN_ARITH_WRITE_CONTROL = 3;
	localparam int LGT_IN_SEL = 4;
	localparam int LGT_CTRL_DIS_POS = 0;
	localparam int LGT_CTRL_INV_POS = 8;
	localparam int LGT_CTRL_ASYNC_POS = 16;

	// Group fields: bit 0 low nibble, bit 1 high nibble, bit 2 ninth flip-flop
	localparam int LGT_GRP_LSR_POS = 0;
	localparam int LGT_GRP_CE_POS = 4;
	localparam int LGT_GRP_ARITH_WRITE_CONTROL_POS = 8;

	localparam int LGT_MODE_POS = 0;
	localparam int LGT_NINTH_SRC_POS = 4;
	localparam int LGT_STAT_F_POS = 16;

	typedef enum logic [2:0] {
		LGT_MODE_LOGIC = 3'h1,
		LGT_MODE_HALF = 3'h2,
		LGT_MODE_RIPPLE = 3'h4
	} lgt_mode_e;

	localparam logic [4:0] LGT_RST_DIS = 5'h00;
	localparam logic [4:0] LGT_RST_INV = 5'h00;
	localparam logic [2:0] LGT_RST_LSR_EN = 3'h7;
	localparam logic [2:0] LGT_RST_CE_EN = 3'h7;
	localparam logic [2:0] LGT_RST_ARITH_WRITE_CONTROL_EN = 3'h0;
	localparam logic [8:0] LGT_RST_SRVAL = 9'h000;
	localparam logic [31:0] LGT_RST_FB = 32'h0000_0000;
endpackage

// ==== hdl/lgt_lut_if.sv ====
// Bundle between the tile top and its LUT evaluator.
// Top drives contents and pins, evaluator returns post-mux LUT outputs.
`timescale 1ns/1ps
interface lgt_lut_if;
	logic [7:0][15:0] contents;
	logic [7:0][3:0] pin;
	logic [3:0] fifth;
	logic [3:0] f5_en;
	logic [31:0] fb;
	logic [7:0] f;
	modport eval (input contents, input pin, input fifth, input f5_en, input fb, output f);
	modport tile (output contents, output pin, output fifth, output f5_en, output fb, input f);
endinterface

// ==== hdl/lgt_lut_eval.sv ====
// Combinational evaluation of eight 4-input LUTs with pair muxes and cascade feedback.
// Assumes the tile top holds all configuration; no state in here.
`timescale 1ns/1ps
module lgt_lut_eval (
	lgt_lut_if.eval lut
);
	logic [7:0] raw;

	genvar k;
	generate
		for (k = 0; k < lgt_pkg::LGT_NLUT; k++) begin : g_lut
			logic [3:0] in_k;
			if (k < 4) begin : g_ext
				assign in_k = lut.pin[k];
			end else begin : g_fb
				// Sources stop below the own pair, so no loop can form
				localparam logic [2:0] LIM = 3'(k & 6);
				logic [7:0] cf;
				assign cf = lut.fb[(k - 4) * lgt_pkg::LGT_FB_W +: lgt_pkg::LGT_FB_W];
				assign in_k[1:0] = lut.pin[k][1:0];
				assign in_k[2] = (cf[0] && cf[4:2] < LIM) ? lut.f[cf[4:2]] : lut.pin[k][2]; // [R16] [R17]
				assign in_k[3] = (cf[1] && cf[7:5] < LIM) ? lut.f[cf[7:5]] : lut.pin[k][3]; // [R16] [R17]
			end
			assign raw[k] = lut.contents[k][in_k];
			if (k % 2 == 0) begin : g_even
				// Odd LUT holds the half for fifth input high
				assign lut.f[k] = (lut.f5_en[k / 2] && lut.fifth[k / 2]) ? raw[k + 1] : raw[k]; // [R13] [R14] [R15]
			end else begin : g_odd
				assign lut.f[k] = raw[k]; // [R12]
			end
		end
	endgenerate
endmodule

// ==== hdl/lgt_tile.sv ====
// Programmable logic tile: control conditioning, nine storage flip-flops, LUT modes.
// Assumes tile pins are synchronous to clk; the tile clock pin is sampled, not a clock.
//
// Overview of operation
// (R1) Global clear forces all flops to configured state
// (R2) Local set/reset configurable synchronous or asynchronous
// (R3) Set or reset value chosen per flop
// (R4) Select input picks direct data or LUT
// (R5) Each control input disabled/inverted by configuration
// (R6) Disabled clock enable means always enabled
// (R7) Disabled local set/reset never touches flops
// (R8) Disabled select routes direct data inputs
// (R9) Per-nibble and ninth-flop control disables
// (R10) Write control is second enable in logic
// (R11) Flops load from LUTs or direct inputs
// (R12) LUT output leaves, registers or muxes
// (R13) Fixed pairs mux onto even output
// (R14) Two LUTs plus fifth select make 5-input
// (R15) Any mix of 4- and 5-input LUTs
// (R16) Feedback muxes cascade LUTs three levels
// (R17) Fed-back output still registered and output
// (R18) Half-logic: upper logic, lower ripple; the code runs half mode exactly as ripple mode
// (R19) Half-logic ninth flop general or carry
// (R20) Carry input feeds ninth flop directly
// (R21) Partner: write control low subtracts, high adds
// (R22) Flops capture on configured tile clock edge
`timescale 1ns/1ps
module lgt_tile (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic global_async_clear_n,
	input wire logic tile_clk,
	input wire logic local_set_reset,
	input wire logic clock_enable,
	input wire logic arith_write_control,
	input wire logic data_select,
	input wire logic [7:0][3:0] lut_in,
	input wire logic [3:0] fifth_input_selects,
	input wire logic [7:0] din,
	input wire logic carry_in,
	input wire logic ripple_carry,
	output logic [7:0] lut_out,
	output logic [7:0] q,
	output logic q9,
	output logic ripple_control
);
	typedef struct packed {
		logic [7:0][15:0] lut;
		logic [4:0] dis;
		logic [4:0] inv;
		logic lsr_async;
		logic [2:0] lsr_en;
		logic [2:0] ce_en;
		logic [2:0] arith_write_control_en;
		logic [2:0] mode;
		logic ninth_src;
		logic [8:0] srval;
		logic [3:0] f5_en;
		logic [31:0] fb;
		logic clk_prev;
		logic [8:0] ff;
		logic [7:0] fout;
		logic rctl;
		logic [31:0] rd;
	} lgt_state_s;

	lgt_state_s st_r;
	lgt_state_s st_nxt;

	lgt_lut_if lif ();

	lgt_lut_eval u_eval (
		.lut(lif.eval)
	);

	assign lif.contents = st_r.lut;
	assign lif.pin = lut_in;
	assign lif.fifth = fifth_input_selects;
	assign lif.f5_en = st_r.f5_en;
	assign lif.fb = st_r.fb;

	// Conditioned control inputs
	logic [4:0] raw_in;
	logic [4:0] cond;
	logic clk_cur;
	logic tedge;
	logic lsr_on;
	logic ce_val;
	logic arith_write_control_ce;
	logic sel_val;
	logic is_logic;
	logic [8:0] dvec;
	logic [8:0] lsr_hit;
	logic [8:0] ce_ok;

	assign raw_in = {data_select, arith_write_control, clock_enable, local_set_reset, tile_clk};
	assign cond = (raw_in ^ st_r.inv) & ~st_r.dis; // [R5]
	assign clk_cur = cond[lgt_pkg::LGT_IN_CLK]; // [R22]
	assign tedge = clk_cur & ~st_r.clk_prev; // [R22]
	assign lsr_on = cond[lgt_pkg::LGT_IN_LSR]; // [R7]
	assign ce_val = st_r.dis[lgt_pkg::LGT_IN_CE] | cond[lgt_pkg::LGT_IN_CE]; // [R6]
	assign is_logic = (st_r.mode == lgt_pkg::LGT_MODE_LOGIC);
	// Write control is a clock enable only in pure logic mode
	assign arith_write_control_ce = is_logic & ~st_r.dis[lgt_pkg::LGT_IN_ARITH_WRITE_CONTROL]; // [R10] [R18]
	assign sel_val = cond[lgt_pkg::LGT_IN_SEL]; // [R4] [R8]

	genvar i;
	generate
		for (i = 0; i < lgt_pkg::LGT_NFF; i++) begin : g_ff
			localparam int G = (i < 4) ? 0 : ((i < 8) ? 1 : 2);
			assign lsr_hit[i] = lsr_on & st_r.lsr_en[G]; // [R9]
			assign ce_ok[i] = (~st_r.ce_en[G] | ce_val)
				& (~(arith_write_control_ce & st_r.arith_write_control_en[G]) | cond[lgt_pkg::LGT_IN_ARITH_WRITE_CONTROL]); // [R6] [R9] [R10]
			if (i < 8) begin : g_d
				assign dvec[i] = sel_val ? lif.f[i] : din[i]; // [R4] [R11] [R12]
			end else begin : g_d9
				// Carry-chain source only outside logic mode
				assign dvec[i] = (st_r.ninth_src && !is_logic) ? ripple_carry : carry_in; // [R19] [R20]
			end
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_prev = clk_cur;
		st_nxt.fout = lif.f; // [R12] [R17]
		// Ripple modes hand the write control to the external carry logic
		st_nxt.rctl = is_logic ? 1'b0 : cond[lgt_pkg::LGT_IN_ARITH_WRITE_CONTROL]; // [R10] [R18] [R21]
		for (int n = 0; n < lgt_pkg::LGT_NFF; n++) begin
			if (!global_async_clear_n) begin
				st_nxt.ff[n] = st_r.srval[n]; // [R1]
			end else if (st_r.lsr_async && lsr_hit[n]) begin
				st_nxt.ff[n] = st_r.srval[n]; // [R2] [R3]
			end else if (tedge) begin
				if (lsr_hit[n]) begin
					st_nxt.ff[n] = st_r.srval[n]; // [R2] [R3]
				end else if (ce_ok[n]) begin
					st_nxt.ff[n] = dvec[n]; // [R22]
				end
			end
		end
		st_nxt.rd = 32'h0000_0000;
		if (rd_en) begin
			if (addr < lgt_pkg::LGT_OFS_CTRL && addr[1:0] == 2'h0) begin
				st_nxt.rd = {16'h0000, st_r.lut[addr[4:2]]};
			end else if (addr == lgt_pkg::LGT_OFS_CTRL) begin
				st_nxt.rd[lgt_pkg::LGT_CTRL_DIS_POS +: 5] = st_r.dis;
				st_nxt.rd[lgt_pkg::LGT_CTRL_INV_POS +: 5] = st_r.inv;
				st_nxt.rd[lgt_pkg::LGT_CTRL_ASYNC_POS] = st_r.lsr_async;
			end else if (addr == lgt_pkg::LGT_OFS_GROUP) begin
				st_nxt.rd[lgt_pkg::LGT_GRP_LSR_POS +: 3] = st_r.lsr_en;
				st_nxt.rd[lgt_pkg::LGT_GRP_CE_POS +: 3] = st_r.ce_en;
				st_nxt.rd[lgt_pkg::LGT_GRP_ARITH_WRITE_CONTROL_POS +: 3] = st_r.arith_write_control_en;
			end else if (addr == lgt_pkg::LGT_OFS_MODE) begin
				st_nxt.rd[lgt_pkg::LGT_MODE_POS +: 3] = st_r.mode;
				st_nxt.rd[lgt_pkg::LGT_NINTH_SRC_POS] = st_r.ninth_src;
			end else if (addr == lgt_pkg::LGT_OFS_SRVAL) begin
				st_nxt.rd[8:0] = st_r.srval;
			end else if (addr == lgt_pkg::LGT_OFS_F5EN) begin
				st_nxt.rd[3:0] = st_r.f5_en;
			end else if (addr == lgt_pkg::LGT_OFS_FB) begin
				st_nxt.rd = st_r.fb;
			end else if (addr == lgt_pkg::LGT_OFS_STATUS) begin
				st_nxt.rd[8:0] = st_r.ff;
				st_nxt.rd[lgt_pkg::LGT_STAT_F_POS +: 8] = st_r.fout;
			end
		end
		if (wr_en) begin
			if (addr < lgt_pkg::LGT_OFS_CTRL && addr[1:0] == 2'h0) begin
				st_nxt.lut[addr[4:2]] = wr_data[15:0]; // [R15]
			end else if (addr == lgt_pkg::LGT_OFS_CTRL) begin
				st_nxt.dis = wr_data[lgt_pkg::LGT_CTRL_DIS_POS +: 5]; // [R5]
				st_nxt.inv = wr_data[lgt_pkg::LGT_CTRL_INV_POS +: 5]; // [R5]
				st_nxt.lsr_async = wr_data[lgt_pkg::LGT_CTRL_ASYNC_POS]; // [R2]
			end else if (addr == lgt_pkg::LGT_OFS_GROUP) begin
				st_nxt.lsr_en = wr_data[lgt_pkg::LGT_GRP_LSR_POS +: 3]; // [R9]
				st_nxt.ce_en = wr_data[lgt_pkg::LGT_GRP_CE_POS +: 3]; // [R9]
				st_nxt.arith_write_control_en = wr_data[lgt_pkg::LGT_GRP_ARITH_WRITE_CONTROL_POS +: 3]; // [R9]
			end else if (addr == lgt_pkg::LGT_OFS_MODE) begin
				st_nxt.mode = wr_data[lgt_pkg::LGT_MODE_POS +: 3];
				st_nxt.ninth_src = wr_data[lgt_pkg::LGT_NINTH_SRC_POS]; // [R19]
			end else if (addr == lgt_pkg::LGT_OFS_SRVAL) begin
				st_nxt.srval = wr_data[8:0]; // [R3]
			end else if (addr == lgt_pkg::LGT_OFS_F5EN) begin
				st_nxt.f5_en = wr_data[3:0]; // [R14]
			end else if (addr == lgt_pkg::LGT_OFS_FB) begin
				st_nxt.fb = wr_data; // [R16]
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.dis <= lgt_pkg::LGT_RST_DIS;
			st_r.inv <= lgt_pkg::LGT_RST_INV;
			st_r.lsr_en <= lgt_pkg::LGT_RST_LSR_EN;
			st_r.ce_en <= lgt_pkg::LGT_RST_CE_EN;
			st_r.arith_write_control_en <= lgt_pkg::LGT_RST_ARITH_WRITE_CONTROL_EN;
			st_r.mode <= lgt_pkg::LGT_MODE_LOGIC;
			st_r.srval <= lgt_pkg::LGT_RST_SRVAL;
			st_r.fb <= lgt_pkg::LGT_RST_FB;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data = st_r.rd;
	assign lut_out = st_r.fout;
	assign q = st_r.ff[7:0];
	assign q9 = st_r.ff[8];
	assign ripple_control = st_r.rctl;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic lo_load;
	assign lo_load = global_async_clear_n & tedge & ~lsr_hit[0] & ce_ok[0];

	sequence clear_held;
		!global_async_clear_n ##1 !global_async_clear_n;
	endsequence

	gclr_force_a: assert property ( // [R1]
		clear_held |=> ({q9, q} == $past(st_r.srval)))
		else $error("global clear did not force configured state");

	async_lsr_a: assert property ( // [R2]
		(global_async_clear_n && st_r.lsr_async && lsr_hit[4] && !wr_en)
		|=> (q[7:4] == $past(st_r.srval[7:4])))
		else $error("async local set/reset missed");

	sync_lsr_a: assert property ( // [R3]
		(global_async_clear_n && !st_r.lsr_async && lsr_hit[4] && tedge)
		|=> (q[7:4] == $past(st_r.srval[7:4])))
		else $error("sync local set/reset wrong value");

	sel_lut_a: assert property ( // [R4]
		(lo_load && sel_val) |=> (q[3:0] == $past(lif.f[3:0])))
		else $error("select high did not load LUT outputs");

	sel_off_a: assert property ( // [R8]
		(lo_load && st_r.dis[lgt_pkg::LGT_IN_SEL]) |=> (q[3:0] == $past(din[3:0])))
		else $error("disabled select did not load direct inputs");

	ce_off_a: assert property ( // [R6]
		(global_async_clear_n && tedge && !lsr_hit[4] && st_r.dis[lgt_pkg::LGT_IN_CE]
		&& !(arith_write_control_ce && st_r.arith_write_control_en[1])) |=> (q[7:4] == $past(dvec[7:4])))
		else $error("disabled clock enable blocked a load");

	lsr_off_a: assert property ( // [R7]
		(global_async_clear_n && st_r.dis[lgt_pkg::LGT_IN_LSR] && !tedge) |=> ({q9, q} == $past({q9, q})))
		else $error("flops changed with no edge and no set/reset");

	nibble_ce_a: assert property ( // [R9]
		(global_async_clear_n && tedge && !lsr_hit[0] && st_r.ce_en[0] && !ce_val)
		|=> (q[3:0] == $past(q[3:0])))
		else $error("low nibble loaded while clock enable low");

	arith_write_control_ce_a: assert property ( // [R10]
		(global_async_clear_n && tedge && !lsr_hit[0] && arith_write_control_ce && st_r.arith_write_control_en[0]
		&& !cond[lgt_pkg::LGT_IN_ARITH_WRITE_CONTROL]) |=> (q[3:0] == $past(q[3:0])))
		else $error("second clock enable ignored");

	ripple_ctl_a: assert property ( // [R18]
		(!is_logic && !wr_en) ##1 !wr_en |=> (ripple_control == $past(cond[lgt_pkg::LGT_IN_ARITH_WRITE_CONTROL])))
		else $error("ripple control not passed in ripple modes");

	f5_pair_a: assert property ( // [R13]
		(st_r.f5_en[0] && fifth_input_selects[0] && !wr_en) |=> (lut_out[0] == $past(st_r.lut[1][lut_in[1]])))
		else $error("pair mux did not place odd LUT on even output");

	ninth_carry_a: assert property ( // [R20]
		(global_async_clear_n && tedge && is_logic && !lsr_hit[8] && ce_ok[8]) |=> (q9 == $past(carry_in)))
		else $error("ninth flop did not take carry input");

	edge_only_a: assert property ( // [R22]
		(global_async_clear_n && !tedge && !lsr_hit[8]) |=> (q9 == $past(q9)))
		else $error("ninth flop changed without a tile clock edge");

	sequence tile_edge_seen;
		global_async_clear_n && tedge;
	endsequence

	gclr_now_a: assert property ( // [R1]
		!global_async_clear_n |=> ({q9, q} == $past(st_r.srval)))
		else $error("global clear missed in one cycle");

	async_ninth_a: assert property ( // [R2]
		(global_async_clear_n && st_r.lsr_async && lsr_hit[8])
		|=> (q9 == $past(st_r.srval[8])))
		else $error("ninth flop async set/reset missed");

	ninth_sync_a: assert property ( // [R3]
		(tile_edge_seen ##0 (!st_r.lsr_async && lsr_hit[8]))
		|=> (q9 == $past(st_r.srval[8])))
		else $error("ninth flop set/reset value wrong");

	rise_edge_a: assert property ( // [R22]
		(!st_r.inv[lgt_pkg::LGT_IN_CLK] && !st_r.dis[lgt_pkg::LGT_IN_CLK]
		&& $stable(st_r.inv) && $stable(st_r.dis)) |-> (tedge == $rose(tile_clk)))
		else $error("tile clock rising edge missed");

	// A change of the invert bit itself may look like an edge, so it is left out
	inv_edge_a: assert property ( // [R22]
		(st_r.inv[lgt_pkg::LGT_IN_CLK] && !st_r.dis[lgt_pkg::LGT_IN_CLK]
		&& $stable(st_r.inv) && $stable(st_r.dis)) |-> (tedge == $fell(tile_clk)))
		else $error("inverted tile clock edge wrong");

	half_ninth_a: assert property ( // [R19]
		(tile_edge_seen ##0 (!is_logic && st_r.ninth_src && !lsr_hit[8] && ce_ok[8]))
		|=> (q9 == $past(ripple_carry)))
		else $error("ninth flop did not take ripple carry");

	rctl_logic_a: assert property ( // [R10]
		is_logic |=> !ripple_control)
		else $error("ripple control driven in logic mode");

	lut_reg_a: assert property ( // [R12]
		1'b1 |=> (lut_out == $past(lif.f)))
		else $error("LUT outputs not registered");

	// Only LUT4 input 2 is checked; the others follow the same path
	fb_cascade_a: assert property ( // [R16] [R17]
		(st_r.fb[1:0] == 2'h1 && !st_r.fb[4] && !(st_r.f5_en[2] && fifth_input_selects[2]))
		|=> (lut_out[4] == $past(st_r.lut[4][{lut_in[4][3], lif.f[st_r.fb[3:2]], lut_in[4][1:0]}])))
		else $error("cascaded LUT input not fed back");

	f5_off_a: assert property ( // [R15]
		!st_r.f5_en[1] |=> (lut_out[2] == $past(st_r.lut[2][lut_in[2]])))
		else $error("four-input LUT changed by pair mux");

	odd_out_a: assert property ( // [R13]
		1'b1 |=> (lut_out[1] == $past(st_r.lut[1][lut_in[1]])))
		else $error("odd LUT output not passed through");
endmodule

// ==== test/lgt_partner.sv ====
// Far-side routing model: shapes tile clock pulses and arithmetic control.
// Assumes the bench asks for pulses at least two clk cycles apart.
`timescale 1ns/1ps
module lgt_partner (
	input wire logic clk,
	input wire logic rstn,
	input wire logic fire,
	input wire logic add_req,
	output logic tile_clk,
	output logic arith_write_control
);
	// Registered copy of fire, so every rise follows a low sample
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tile_clk <= 1'b0;
			arith_write_control <= 1'b0;
		end else begin
			tile_clk <= fire;
			// High asks for addition, low for subtraction
			arith_write_control <= add_req;
		end
	end
endmodule

// ==== test/lgt_tile_tb.sv ====
// Self-checking bench for the logic tile: register port, flops, LUT modes.
// Assumes the tile, its LUT evaluator and lgt_partner are compiled first.
`timescale 1ns/1ps
module lgt_tile_tb;
	logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic [7:0] addr = '0, din = '0, lo, q;
	logic [31:0] wr_data = '0, rd_data;
	logic gclr_n = 1'b1, fire = 1'b0, add = 1'b0, tclk, awc, srst = 1'b0, ce = 1'b1;
	logic dsel = 1'b0, cy = 1'b0, rcy = 1'b0, q9, rpc, erc = 1'b0;
	logic [7:0][3:0] kin = '0;
	logic [3:0] fsel = '0;
	logic [8:0] eq = '0;
	int lut[8], srv, pair_en, fbv = 0, checked = 0, mismatches = 0, cycles = 0;

	lgt_tile lgt_tile_inst (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .global_async_clear_n(gclr_n), .tile_clk(tclk),
		.local_set_reset(srst), .clock_enable(ce), .arith_write_control(awc), .data_select(dsel),
		.lut_in(kin), .fifth_input_selects(fsel), .din(din), .carry_in(cy), .ripple_carry(rcy),
		.lut_out(lo), .q(q), .q9(q9), .ripple_control(rpc));
	lgt_partner lgt_partner_inst (.clk(clk), .rstn(rstn), .fire(fire), .add_req(add), .tile_clk(tclk),
		.arith_write_control(awc));

	initial begin
		forever #50 clk = ~clk;
	end

	function automatic logic [7:0] feval();
		logic [7:0] f;
		logic [7:0] c;
		logic [3:0] x;
		for (int k = 0; k < 8; k++) begin
			x = kin[k];
			c = (k < 4) ? 8'h00 : 8'(fbv >> (8 * (k - 4)));
			// Feedback only from LUTs below the own pair
			if (c[0] && c[4:2] < (k & 6)) x[2] = f[c[4:2]];
			if (c[1] && c[7:5] < (k & 6)) x[3] = f[c[7:5]];
			f[k] = lut[k][x];
			if (k % 2 == 1 && pair_en[k / 2] && fsel[k / 2]) f[k - 1] = f[k];
		end
		return f;
	endfunction

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic cmp_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		checked++;
		if (rd_data !== e) begin
			mismatches++;
			$display("Error %0t: read %h got %h want %h", $time, a, rd_data, e);
		end
	endtask

	task automatic cmp_out();
		checked++;
		if ({rpc, lo, q9, q} !== {erc, feval(), eq}) begin
			mismatches++;
			$display("Error %0t: outputs %h want %h", $time, {rpc, lo, q9, q}, {erc, feval(), eq});
		end
	endtask

	// Waits n edges after fire falls back low
	task automatic pulse(input int n);
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic new_data();
		@(posedge clk);
		din <= 8'($urandom);
		cy <= 1'($urandom);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(97));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		cmp_rd(lgt_pkg::LGT_OFS_GROUP, 32'h0000_0077);
		cmp_rd(lgt_pkg::LGT_OFS_MODE, 32'h0000_0001);
		cmp_rd(8'h3C, 32'h0000_0000);
		cmp_rd(lgt_pkg::LGT_OFS_STATUS, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			new_data();
			pulse(2);
			eq = {cy, din};
			cmp_out();
		end
		for (int k = 0; k < 8; k++) begin
			lut[k] = $urandom & 32'h0000_FFFF;
			wr(8'(4 * k), 32'(lut[k]));
		end
		cmp_rd(8'h1C, 32'(lut[7]));
		// Pairs 0 and 2 as five-input, 1 and 3 as four-input
		pair_en = 5;
		wr(lgt_pkg::LGT_OFS_F5EN, 32'h0000_0005);
		for (int i = 0; i < 12; i++) begin
			if (i == 6) begin
				fbv = ($urandom & 32'hFFFF_FFEC) | 32'h0000_0001;
				wr(lgt_pkg::LGT_OFS_FB, 32'(fbv));
			end
			@(posedge clk);
			dsel <= 1'b1;
			kin <= 32'($urandom);
			fsel <= 4'($urandom);
			pulse(2);
			eq[7:0] = feval();
			cmp_out();
		end
		$display("test luts done");
		@(posedge clk);
		ce <= 1'b0;
		new_data();
		pulse(2);
		cmp_out();
		wr(lgt_pkg::LGT_OFS_CTRL, 32'h0000_0014);
		pulse(2);
		eq = {cy, din};
		cmp_out();
		wr(lgt_pkg::LGT_OFS_CTRL, 32'h0000_0010);
		wr(lgt_pkg::LGT_OFS_GROUP, 32'h0000_0017);
		new_data();
		pulse(2);
		eq = {cy, din[7:4], eq[3:0]};
		cmp_out();
		@(posedge clk);
		ce <= 1'b1;
		wr(lgt_pkg::LGT_OFS_GROUP, 32'h0000_0177);
		new_data();
		pulse(2);
		eq = {cy, din[7:4], eq[3:0]};
		cmp_out();
		// Half-logic then ripple, ninth flop fed from the ripple chain
		for (int a = 0; a < 2; a++) begin
			wr(lgt_pkg::LGT_OFS_MODE, (a == 0) ? 32'h0000_0012 : 32'h0000_0014);
			@(posedge clk);
			add <= 1'(a);
			rcy <= 1'($urandom);
			din <= 8'($urandom);
			pulse(2);
			eq = {rcy, din};
			erc = 1'(a);
			cmp_out();
		end
		wr(lgt_pkg::LGT_OFS_MODE, 32'h0000_0001);
		erc = 1'b0;
		$display("test enables done");
		srv = $urandom & 32'h0000_01FF;
		wr(lgt_pkg::LGT_OFS_SRVAL, 32'(srv));
		@(posedge clk);
		gclr_n <= 1'b0;
		repeat (2) @(posedge clk);
		gclr_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		eq = 9'(srv);
		cmp_out();
		wr(lgt_pkg::LGT_OFS_GROUP, 32'h0000_0176);
		new_data();
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmp_out();
		pulse(2);
		eq[3:0] = din[3:0];
		cmp_out();
		@(posedge clk);
		srst <= 1'b0;
		new_data();
		pulse(2);
		eq = {cy, din};
		wr(lgt_pkg::LGT_OFS_CTRL, 32'h0001_0010);
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		eq[8:4] = 5'(srv >> 4);
		cmp_out();
		wr(lgt_pkg::LGT_OFS_CTRL, 32'h0001_0012);
		new_data();
		pulse(2);
		eq = {cy, din};
		cmp_out();
		$display("test set reset done");
		@(posedge clk);
		srst <= 1'b0;
		wr(lgt_pkg::LGT_OFS_CTRL, 32'h0000_0110);
		cmp_rd(lgt_pkg::LGT_OFS_CTRL, 32'h0000_0110);
		new_data();
		pulse(1);
		cmp_out();
		@(posedge clk);
		#1;
		eq = {cy, din};
		cmp_out();
		$display("test clock invert done");
		wrap_up();
	end
endmodule
